// ==== verilog/lcd_drive_pkg.sv ====
package lcd_drive_pkg;

  // ****************************************************************
  // Register map (AHB-Lite byte addresses)
  // ****************************************************************
  localparam logic [7:0] ctrl_offset = 8'h00;
  localparam logic [7:0] status_offset = 8'h04;
  localparam logic [7:0] data_offset = 8'h08;
  localparam logic [7:0] pointer_offset = 8'h0c;

  // ****************************************************************
  // Field positions in the control register
  // ****************************************************************
  localparam int ctrl_mode_lsb = 0;
  localparam int ctrl_half_bias_bit = 2;
  localparam int ctrl_enable_bit = 3;
  localparam int ctrl_power_save_bit = 4;
  localparam int ctrl_blink_lsb = 5;
  localparam int ctrl_in_bank_bit = 7;
  localparam int ctrl_out_bank_bit = 8;

  // ****************************************************************
  // Modes and reset values
  // ****************************************************************
  typedef enum logic [1:0] {
    mode_static = 2'h1,
    mode_mux2 = 2'h2,
    mode_mux3 = 2'h3,
    mode_mux4 = 2'h0
  } drive_mode_type;

  typedef struct packed {
    logic out_bank;
    logic in_bank;
    logic [1:0] blink;
    logic power_save;
    logic enable;
    logic half_bias;
    drive_mode_type mode;
  } drive_cfg_type;

  localparam drive_cfg_type cfg_reset = '{
    out_bank: 1'b0, in_bank: 1'b0, blink: 2'h0, power_save: 1'b0,
    enable: 1'b0, half_bias: 1'b0, mode: mode_mux4
  };

  localparam int segment_count = 40;
  localparam int backplane_count = 4;
  localparam logic [5:0] pointer_reset = 6'h00;
  localparam logic [2:0] subaddr_reset = 3'h0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int clk_hz = 20000000;
  localparam int frame_div_normal = 2880;
  localparam int frame_div_save = 480;
  localparam int por_time_us = 1000;
  localparam int por_cycles = (por_time_us * (clk_hz / 1000000));

endpackage

// ==== verilog/lcd_drive_mode_clock_control.sv ====
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
// What this block does
// - Reset drives all backplane and segment outputs to supply high.
// - Reset selects four backplanes, third bias.
// - Reset turns blinking off.
// - Reset clears input and output bank selectors.
// - Reset clears bus logic, pointer, subaddress.
// - Sequencing follows latest mode setting.
// - Half bias in two-backplane bypasses resistor.
// - Static mode uses one backplane, two levels.
// - Two-backplane mode allows half or third bias.
// - Three/four-backplane default third, allow half.
// - Four time slots per frame in every mode, one per active backplane, the rest idle.
// - Frame timing and display RAM writes run from one working clock.
// - Strap low: internal oscillator, clock out.
// - Strap high: oscillator off, clock pin input.
// - Frame is clock over 2880 or 480.
// - Stall a data write while display byte is pending.
module lcd_drive_mode_clock_control #(
  parameter int por_count = lcd_drive_pkg::por_cycles,
  parameter int div_normal = lcd_drive_pkg::frame_div_normal,
  parameter int div_save = lcd_drive_pkg::frame_div_save
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [7:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // Clock strap and clock pin
  input wire logic i_osc_select,
  input wire logic i_osc_tick,
  input wire logic i_clk_pin_in,
  output logic o_clk_pin_out,
  output logic o_clk_pin_oe,
  output logic o_osc_enable,
  // Panel drive
  output logic [3:0] o_backplane_outputs,
  output logic [39:0] o_segment_outputs,
  output logic o_bias_bypass,
  output logic o_frame_rate
);
  import lcd_drive_pkg::*;

  // ****************************************************************
  // Strap and power-on timer
  // ****************************************************************
  logic strap_q;
  logic por_done_q;
  logic [23:0] por_cnt_q;

  // The strap is only taken while the timer runs, so a late glitch cannot swap clocks mid-frame.
  // strap latched after reset.
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      strap_q <= 1'b0;
    end else if (!por_done_q) begin
      strap_q <= i_osc_select;
    end
  end

  // Bus writes wait for this timer, so an early host loses them instead of racing the reset.
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      por_cnt_q <= 24'h000000;
      por_done_q <= 1'b0;
    end else if (!por_done_q) begin
      por_cnt_q <= por_cnt_q + 24'h000001;
      if (por_cnt_q >= 24'(por_count - 1)) begin
        por_done_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Clock selection and working tick
  // ****************************************************************
  // internal oscillator drives the clock pin.
  assign o_osc_enable = ~strap_q;
  assign o_clk_pin_oe = ~strap_q;

  // one working tick from either source.
  logic pin_d1_q;
  logic pin_d2_q;
  logic pin_d3_q;
  logic work_tick;
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_d1_q <= 1'b0;
      pin_d2_q <= 1'b0;
      pin_d3_q <= 1'b0;
    end else begin
      pin_d1_q <= i_clk_pin_in;
      pin_d2_q <= pin_d1_q;
      pin_d3_q <= pin_d2_q;
    end
  end
  assign work_tick = strap_q ? (pin_d2_q & ~pin_d3_q) : i_osc_tick;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_clk_pin_out <= 1'b0;
    end else if (!strap_q && i_osc_tick) begin
      o_clk_pin_out <= ~o_clk_pin_out;
    end
  end

  // ****************************************************************
  // Register bus
  // ****************************************************************
  drive_cfg_type cfg_q;
  logic [5:0] pointer_q;
  logic [2:0] subaddr_q;
  logic [3:0] ram_q [0:segment_count-1];
  logic pend_q;
  logic [7:0] pend_data_q;
  logic ph_wr_q;
  logic [7:0] ph_addr_q;
  logic stall;

  // Only a data write can stall; every other access answers at once.
  // data phase stretched while a byte waits.
  assign stall = ph_wr_q && (ph_addr_q == data_offset) && pend_q;
  assign o_hreadyout = ~stall;
  assign o_hresp = 1'b0;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ph_wr_q <= 1'b0;
      ph_addr_q <= 8'h00;
    end else if (i_hready) begin
      ph_wr_q <= i_hsel && i_htrans[1] && i_hwrite && por_done_q;
      ph_addr_q <= i_haddr;
    end
  end

  // reset mode four backplanes third bias.
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_q <= cfg_reset;
    end else if (ph_wr_q && !stall && ph_addr_q == ctrl_offset) begin
      cfg_q <= drive_cfg_type'(i_hwdata[8:0]);
    end
  end

  // pointer and subaddress cleared on reset.
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pointer_q <= pointer_reset;
      subaddr_q <= subaddr_reset;
    end else if (ph_wr_q && !stall && ph_addr_q == pointer_offset) begin
      pointer_q <= i_hwdata[5:0];
      subaddr_q <= i_hwdata[10:8];
    end else if (pend_q && work_tick) begin
      pointer_q <= (pointer_q >= 6'(segment_count - 1)) ? pointer_reset
                                                        : pointer_q + 6'h01;
    end
  end

  // A pending byte always clears on the tick that stores it, so a pointer write in
  // the same cycle cannot make it land twice.
  // one byte waits here for the working tick.
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pend_q <= 1'b0;
      pend_data_q <= 8'h00;
    end else if (ph_wr_q && !stall && ph_addr_q == data_offset) begin
      pend_q <= 1'b1;
      pend_data_q <= i_hwdata[7:0];
    end else if (work_tick) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (pend_q && work_tick) begin
      ram_q[pointer_q] <= pend_data_q[3:0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_hrdata <= 32'h00000000;
    end else if (i_hready && i_hsel && i_htrans[1] && !i_hwrite) begin
      case (i_haddr)
        ctrl_offset: o_hrdata <= {23'h000000, cfg_q};
        status_offset: o_hrdata <= {28'h0000000, pend_q, por_done_q, strap_q, o_bias_bypass};
        pointer_offset: o_hrdata <= {21'h000000, subaddr_q, 2'h0, pointer_q};
        default: o_hrdata <= 32'h00000000;
      endcase
    end
  end

  // ****************************************************************
  // Frame timing and backplane phase
  // ****************************************************************
  logic [11:0] slot_cnt_q;
  logic [1:0] phase_q;
  logic [1:0] last_phase;
  logic [11:0] slot_len;

  always_comb begin
    case (cfg_q.mode)
      mode_static: last_phase = 2'h0;
      mode_mux2: last_phase = 2'h1;
      mode_mux3: last_phase = 2'h2;
      default: last_phase = 2'h3;
    endcase
  end

  // frame length is 2880 or 480 ticks.
  assign slot_len = cfg_q.power_save ? 12'(div_save / 4) : 12'(div_normal / 4);

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      slot_cnt_q <= 12'h000;
      phase_q <= 2'h0;
      o_frame_rate <= 1'b0;
    end else if (work_tick) begin
      if (slot_cnt_q >= slot_len - 12'h001) begin
        slot_cnt_q <= 12'h000;
        if (phase_q == 2'h3) begin
          phase_q <= 2'h0;
          o_frame_rate <= ~o_frame_rate;
        end else begin
          phase_q <= phase_q + 2'h1;
        end
      end else begin
        slot_cnt_q <= slot_cnt_q + 12'h001;
      end
    end
  end

  // ****************************************************************
  // Panel outputs
  // ****************************************************************
  logic [1:0] row;
  logic slot_active;
  assign row = phase_q;
  assign slot_active = (phase_q <= last_phase);

  // resistor bypass for half bias two-backplane.
  // half bias accepted in three/four mode.
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_bias_bypass <= 1'b0;
    end else begin
      o_bias_bypass <= cfg_q.half_bias && (cfg_q.mode == mode_mux2);
    end
  end

  // Unused backplanes stay low rather than mirroring a used one, so each mode shows its count.
  function automatic logic bp_in_slot(input int b, input logic [1:0] ph,
                                      input logic [1:0] last);
    bp_in_slot = (ph <= last) && (2'(b) == ph);
  endfunction

  // outputs at supply high until enabled.
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_backplane_outputs <= 4'hf;
    end else if (!cfg_q.enable) begin
      o_backplane_outputs <= 4'hf;
    end else begin
      for (int b = 0; b < backplane_count; b++) begin
        o_backplane_outputs[b] <= bp_in_slot(b, row, last_phase);
      end
    end
  end

  // A segment shows its RAM bit for the current backplane row.
  genvar s;
  generate
    for (s = 0; s < segment_count; s++) begin : g_seg
      always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          o_segment_outputs[s] <= 1'b1;
        end else begin
          o_segment_outputs[s] <= !cfg_q.enable || (slot_active && ram_q[s][row]);
        end
      end
    end
  endgenerate

endmodule

// ==== tb/lcd_panel_model.sv ====
`timescale 1ns/1ps
module lcd_panel_model (
  // Clock, clear and panel lines
  input wire logic i_sys_clk,
  input wire logic i_clear,
  input wire logic [3:0] i_backplane_outputs,
  output logic [3:0] o_seen
);
  // The panel only loads its lines, so it just records which backplanes got a slot.
  // All lines high is the unconfigured state and is not a slot.
  always_ff @(posedge i_sys_clk) begin
    if (i_clear) begin
      o_seen <= 4'h0;
    end else if (i_backplane_outputs != 4'hf) begin
      o_seen <= o_seen | i_backplane_outputs;
    end
  end
endmodule

// ==== tb/lcd_drive_checker.sv ====
`timescale 1ns/1ps
module lcd_drive_checker
  import lcd_drive_pkg::*;
#(parameter int div_normal = frame_div_normal, parameter int div_save = frame_div_save) (
  // Clock, reset and bus
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_hsel,
  input wire logic [7:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  // Clock pin and panel
  input wire logic i_osc_select,
  input wire logic i_osc_tick,
  input wire logic o_clk_pin_out,
  input wire logic o_clk_pin_oe,
  input wire logic o_osc_enable,
  input wire logic [3:0] o_backplane_outputs,
  input wire logic [39:0] o_segment_outputs,
  input wire logic o_bias_bypass,
  input wire logic o_frame_rate
);
  logic wa_q, fr_q, ok_q;
  logic [8:0] cfg_q;
  logic [3:0] bp_q;
  int cnt_q;
  wire wc = wa_q && o_hreadyout;
  wire tg = o_frame_rate != fr_q;
  wire [3:0] bp = o_backplane_outputs;
  wire mv = bp != bp_q;
  // The first frame after a setting change may be partial, so ok_q waits for a boundary.
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wa_q <= 1'b0;
      cfg_q <= 9'h0;
      fr_q <= 1'b0;
      bp_q <= 4'hf;
      ok_q <= 1'b0;
      cnt_q <= 0;
    end else begin
      if (i_hready) begin
        wa_q <= i_hsel && i_htrans[1] && i_hwrite && i_haddr == ctrl_offset;
      end
      if (wc) begin
        cfg_q <= i_hwdata[8:0];
      end
      fr_q <= o_frame_rate;
      bp_q <= bp;
      ok_q <= !wc && (ok_q || tg);
      cnt_q <= tg ? int'(i_osc_tick) : cnt_q + int'(i_osc_tick);
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  AST_RST_HIGH: assert property ($rose(i_rst_b) |-> &bp && &o_segment_outputs)
    else $error("panel outputs not high after reset");
  AST_BYPASS: assert property ($stable(cfg_q) [*3] |-> o_bias_bypass == (cfg_q[2:0] == 3'h6))
    else $error("bias bypass does not follow mode");
  AST_INT_OSC: assert property (!i_osc_select [*4] |-> o_clk_pin_oe && o_osc_enable)
    else $error("internal oscillator not selected");
  AST_EXT_CLK: assert property (i_osc_select [*4] |-> !o_clk_pin_oe && !o_osc_enable)
    else $error("clock pin not an input");
  AST_CLK_OUT: assert property (!i_osc_select && o_osc_enable && i_osc_tick |=> $changed(o_clk_pin_out))
    else $error("clock out missed a tick");
  AST_STATIC: assert property (cfg_q[3] && cfg_q[1:0] == 2'h1 && $stable(cfg_q) && mv
    && bp_q != 4'hf |-> bp[3:1] == 3'h0)
    else $error("static mode used another backplane");
  AST_ROTATE: assert property (cfg_q[3] && cfg_q[1:0] == 2'h0 && $stable(cfg_q) && mv
    && $onehot(bp_q) |-> bp == {bp_q[2:0], bp_q[3]})
    else $error("backplane order broken");
  AST_FRAME: assert property (tg && ok_q && !i_osc_select
    |-> cnt_q == (cfg_q[4] ? div_save : div_normal))
    else $error("frame length wrong");
  cover property (tg && ok_q && cfg_q[4]);
  cover property (o_bias_bypass);
  cover property (!o_hreadyout);
endmodule
bind lcd_drive_mode_clock_control lcd_drive_checker #(.div_normal(div_normal),
  .div_save(div_save)) i_chk (.i_sys_clk, .i_rst_b, .i_hsel, .i_haddr, .i_htrans,
  .i_hwrite, .i_hwdata, .i_hready, .o_hreadyout, .i_osc_select, .i_osc_tick,
  .o_clk_pin_out, .o_clk_pin_oe, .o_osc_enable, .o_backplane_outputs,
  .o_segment_outputs, .o_bias_bypass, .o_frame_rate);

// ==== tb/test_lcd_drive_mode_clock_control.sv ====
`timescale 1ns/1ps
module test_lcd_drive_mode_clock_control;
  import lcd_drive_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic strap = 1'b0;
  logic tick = 1'b0;
  logic ext = 1'b0;
  logic clr = 1'b0;
  logic [31:0] hrdata, r;
  logic rdy, clk_out, oe, osc_en, bypass, frame, hresp;
  logic [3:0] bp, seen;
  logic [39:0] seg;
  int failures = 0;
  int n_compared = 0;
  int stalls = 0;
  int ph = 0;
  int tdiv = 4;
  int n;
  drive_mode_type modes[4] = '{mode_static, mode_mux2, mode_mux3, mode_mux4};
  logic [3:0] masks[4] = '{4'h1, 4'h3, 4'h7, 4'hf};
  // The pin is ours only while the device has released it.
  wire pin = oe ? clk_out : ext;
  always #25 i_sys_clk = ~i_sys_clk;
  // the tick comes once every tdiv clocks, below the bus rate, and stops while osc_en is low.
  always @(posedge i_sys_clk) begin
    ph <= (ph + 1) % tdiv;
    tick <= ph == 0 && osc_en;
    ext <= strap && ph < tdiv / 2;
  end
  lcd_drive_mode_clock_control #(.por_count(16), .div_normal(48), .div_save(8)) i_dut (
    .i_sys_clk, .i_rst_b, .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(rdy),
    .o_hrdata(hrdata), .o_hreadyout(rdy), .o_hresp(hresp), .i_osc_select(strap),
    .i_osc_tick(tick), .i_clk_pin_in(pin), .o_clk_pin_out(clk_out), .o_clk_pin_oe(oe),
    .o_osc_enable(osc_en), .o_backplane_outputs(bp), .o_segment_outputs(seg),
    .o_bias_bypass(bypass), .o_frame_rate(frame));
  lcd_panel_model i_panel (.i_sys_clk, .i_clear(clr), .i_backplane_outputs(bp),
    .o_seen(seen));
  task automatic test_done();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Ready is read at the falling edge, where it already holds what the next rising edge sees.
  task automatic phase();
    logic ok;
    int k;
    k = 0;
    do begin
      @(negedge i_sys_clk);
      ok = rdy;
      r = hrdata;
      stalls += int'(ok !== 1'b1);
      @(posedge i_sys_clk);
      k++;
    end while (ok !== 1'b1 && k < 300);
    if (ok !== 1'b1) begin
      failures++;
      test_done();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    phase();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    phase();
  endtask
  task automatic slots(input int c);
    clr <= 1'b1;
    @(posedge i_sys_clk);
    clr <= 1'b0;
    repeat (c) @(posedge i_sys_clk);
  endtask
  initial begin
    repeat (5) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    bus(1'b1, data_offset, 32'hf);
    repeat (20) @(posedge i_sys_clk);
    bus(1'b0, pointer_offset, 32'h0);
    chk(r, 32'h0);
    bus(1'b0, ctrl_offset, 32'h0);
    chk(r, 32'(cfg_reset));
    chk({31'h0, &{bp, seg}}, 32'h1);
    bus(1'b0, status_offset, 32'h0);
    chk(r, 32'h4);
    bus(1'b0, 8'h10, 32'h0);
    chk(r, 32'h0);
    foreach (modes[i]) begin
      for (int h = 0; h < 2; h++) begin
        bus(1'b1, ctrl_offset, {29'h1, 1'(h), modes[i]});
        bus(1'b0, ctrl_offset, 32'h0);
        chk(r, {29'h1, 1'(h), modes[i]});
        bus(1'b0, status_offset, 32'h0);
        chk(r & 32'h1, {31'h0, h == 1 && modes[i] == mode_mux2});
        slots(400);
        chk({28'h0, seen}, {28'h0, masks[i]});
      end
    end
    bus(1'b1, ctrl_offset, 32'h18);
    tdiv <= 16;
    repeat (300) @(posedge i_sys_clk);
    bus(1'b1, pointer_offset, 32'h0);
    stalls = 0;
    bus(1'b1, data_offset, 32'h1);
    bus(1'b1, data_offset, 32'h2);
    bus(1'b1, data_offset, 32'h4);
    chk(32'(stalls != 0), 32'h1);
    chk({31'h0, hresp}, 32'h0);
    // Two bytes are stored by now and the third still waits for its tick.
    bus(1'b0, pointer_offset, 32'h0);
    chk(r, 32'h2);
    bus(1'b0, status_offset, 32'h0);
    chk(r & 32'h8, 32'h8);
    repeat (20) @(posedge i_sys_clk);
    n = 0;
    while (bp !== 4'h2 && n < 2000) begin
      @(negedge i_sys_clk);
      n++;
    end
    if (bp !== 4'h2) begin
      failures++;
      test_done();
    end
    chk({29'h0, seg[2:0]}, 32'h2);
    @(posedge i_sys_clk);
    i_rst_b <= 1'b0;
    strap <= 1'b1;
    tdiv <= 4;
    repeat (5) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    repeat (20) @(posedge i_sys_clk);
    bus(1'b0, status_offset, 32'h0);
    chk(r, 32'h6);
    chk({30'h0, oe, osc_en}, 32'h0);
    bus(1'b1, ctrl_offset, 32'h8);
    slots(500);
    chk({28'h0, seen}, 32'hf);
    test_done();
  end
endmodule
